// ==== hw/ira_params.svh ====
// Constants for the I2C register-access target: widths, reset values, bit positions.
// Assumes inclusion by its bare name from design files that also use ira_pkg.
`ifndef IRA_PARAMS_SVH
`define IRA_PARAMS_SVH

// Width of the register pointer carried in two address bytes.
`define IRA_ADDR_W      16
// Bits in one byte on the wire.
`define IRA_BYTE_W      8
// Index of the last bit of a byte.
`define IRA_LAST_BIT    3'h7
// Default seven-bit target address; the value is arbitrary.
`define IRA_DEV_ADDR    7'h2A
// Reset value of the register pointer.
`define IRA_ADDR_RST    16'h0000
// Reset value of byte-wide data registers.
`define IRA_BYTE_RST    8'h00
// Direction bit value that selects a read.
`define IRA_DIR_READ    1'h1
// Level of the acknowledge bit on the wire.
`define IRA_ACK_LVL     1'h0
// Address byte counter values: high byte, low byte, data.
`define IRA_IDX_HI      2'h0
`define IRA_IDX_LO      2'h1
`define IRA_IDX_DATA    2'h2

`endif

// ==== hw/ira_pkg.sv ====
// Types shared by the I2C register-access target.
// Assumes the constants of ira_params.svh for the widths used beside these types.
package ira_pkg;

	// Transaction states of the byte-level engine.
	typedef enum logic [2:0] {
		IRA_IDLE,
		IRA_ADDR,
		IRA_RX,
		IRA_ACK_DRV,
		IRA_ACK_HOLD,
		IRA_TX,
		IRA_TX_REL,
		IRA_TX_ACK
	} ira_state_e;

endpackage

// ==== hw/ira_link_cap.sv ====
// Bit sampler that runs on the serial clock of the link.
// Assumes scl_clk is the bus clock pin; it may stand still between frames.
`timescale 1ns/10ps
module ira_link_cap (
	input  wire logic scl_clk,      // Bus clock, used as a clock here.
	input  wire logic rst_n,        // Asynchronous reset, active low.
	input  wire logic sda_i,        // Data line level as seen at the pin.
	output logic      bit_tgl,      // Flips once for every bit sampled.
	output logic      bit_val       // Value of the latest sampled bit.
);

	logic tgl_ff;                   // Toggle that marks a fresh bit.
	logic val_ff;                   // Bit caught on the rising clock.
	logic nxt_tgl;                  // Next toggle value.
	logic nxt_val;                  // Next captured bit.

	// Every rising edge delivers one bit; the toggle lets the system clock
	// see it as an event without sharing a pulse across domains.
	always_comb begin
		nxt_tgl = ~tgl_ff;
		nxt_val = sda_i;
	end

	// The value stays put for a whole bus period, far longer than the
	// toggle needs to cross, so it is read as stable data on the far side.
	always_ff @(posedge scl_clk or negedge rst_n) begin
		if (!rst_n) begin
			tgl_ff <= 1'b0;
			val_ff <= 1'b0;
		end else begin
			tgl_ff <= nxt_tgl;
			val_ff <= nxt_val;
		end
	end

	assign bit_tgl = tgl_ff;
	assign bit_val = val_ff;

endmodule

// ==== hw/ira_i2c_target.sv ====
// I2C target that reaches a 16-bit addressed register space.
// Assumes an external master drives the bus clock and a register file
// outside that presents rd_data for reg_addr within one system clock.
`timescale 1ns/10ps
`include "ira_params.svh"
module ira_i2c_target #(
	parameter logic [6:0] DEV_ADDR = `IRA_DEV_ADDR  // Seven-bit target address.
) (
	input  wire logic                    clk,       // System clock, 20 MHz.
	input  wire logic                    rst_n,     // Asynchronous reset, active low.
	input  wire logic                    ce,        // Clock enable; low freezes all state but the bus-clocked link capture.
	input  wire logic                    scl,       // Bus clock pin.
	input  wire logic                    sda_i,     // Data line level.
	output logic                         sda_o,     // Data line drive value, always low.
	output logic                         sda_oe,    // High while the line is pulled low.
	output logic [`IRA_ADDR_W-1:0]       reg_addr,  // Register pointer.
	output logic [`IRA_BYTE_W-1:0]       wr_data,   // Byte to store at reg_addr.
	output logic                         wr_stb,    // One-cycle write strobe.
	output logic                         rd_stb,    // One-cycle strobe: rd_data taken.
	input  wire logic [`IRA_BYTE_W-1:0]  rd_data,   // Register content at reg_addr.
	output logic                         busy       // High while addressed in a frame.
);

	// Three-stage synchronisers for the pins and the link toggle.
	logic scl_s1_ff, scl_s2_ff, scl_s3_ff;         // Bus clock stages.
	logic sda_s1_ff, sda_s2_ff, sda_s3_ff;         // Data line stages.
	logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;         // Bit toggle stages.
	logic scl_lv_ff, sda_lv_ff, tgl_lv_ff;         // Accepted stable levels.
	logic nxt_scl_lv, nxt_sda_lv, nxt_tgl_lv;      // Next accepted levels.
	logic start_ev, stop_ev, fall_ev, bit_ev;      // Decoded bus events.
	logic link_tgl;                                // Toggle from the link domain.
	logic link_bit;                                // Bit from the link domain.

	// Transaction engine state.
	ira_pkg::ira_state_e       state_ff, nxt_state;     // Engine state.
	logic [2:0]                cnt_ff, nxt_cnt;         // Bits done in the byte.
	logic [6:0]                sh_ff, nxt_sh;           // Received bits so far.
	logic [`IRA_BYTE_W-1:0]    tx_ff, nxt_tx;           // Byte being sent.
	logic [1:0]                idx_ff, nxt_idx;         // Which byte of a write.
	logic                      rw_ff, nxt_rw;           // Direction of this frame.
	logic                      inc_ff, nxt_inc;         // Pointer bump pending.
	logic                      oe_ff, nxt_oe;           // Line pull-down.
	logic [`IRA_ADDR_W-1:0]    addr_ff, nxt_addr;       // Register pointer.
	logic [`IRA_BYTE_W-1:0]    wd_ff, nxt_wd;           // Write data.
	logic                      wstb_ff, nxt_wstb;       // Write strobe.
	logic                      rstb_ff, nxt_rstb;       // Read strobe.
	logic [`IRA_BYTE_W-1:0]    rx_byte;                 // Byte completed by this bit.
	logic                      busy_ff, nxt_busy;       // Addressed flag; lags the state a cycle.

	// The bus clock edge that samples each bit lives in its own domain.
	ira_link_cap u_cap (
		.scl_clk (scl),
		.rst_n   (rst_n),
		.sda_i   (sda_i),
		.bit_tgl (link_tgl),
		.bit_val (link_bit)
	);

	// A level is accepted only once the second and third stages agree, which
	// rejects a single metastable or glitchy sample without a separate filter.
	function automatic logic settle(input logic s2, input logic s3, input logic cur);
		settle = (s2 == s3) ? s3 : cur;
	endfunction

	// Next accepted levels and the events they imply.
	always_comb begin
		nxt_scl_lv = settle(scl_s2_ff, scl_s3_ff, scl_lv_ff);
		nxt_sda_lv = settle(sda_s2_ff, sda_s3_ff, sda_lv_ff);
		nxt_tgl_lv = settle(tgl_s2_ff, tgl_s3_ff, tgl_lv_ff);
		// Data moving while the clock stays high marks start or stop.
		start_ev = scl_lv_ff && nxt_scl_lv && sda_lv_ff && !nxt_sda_lv;
		stop_ev  = scl_lv_ff && nxt_scl_lv && !sda_lv_ff && nxt_sda_lv;
		fall_ev  = scl_lv_ff && !nxt_scl_lv;
		bit_ev   = (nxt_tgl_lv != tgl_lv_ff);
	end

	// Synchroniser registers; the first stage feeds only the second.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_s1_ff <= 1'b1;
			scl_s2_ff <= 1'b1;
			scl_s3_ff <= 1'b1;
			sda_s1_ff <= 1'b1;
			sda_s2_ff <= 1'b1;
			sda_s3_ff <= 1'b1;
			tgl_s1_ff <= 1'b0;
			tgl_s2_ff <= 1'b0;
			tgl_s3_ff <= 1'b0;
			scl_lv_ff <= 1'b1;
			sda_lv_ff <= 1'b1;
			tgl_lv_ff <= 1'b0;
		end else if (ce) begin
			scl_s1_ff <= scl;
			scl_s2_ff <= scl_s1_ff;
			scl_s3_ff <= scl_s2_ff;
			sda_s1_ff <= sda_i;
			sda_s2_ff <= sda_s1_ff;
			sda_s3_ff <= sda_s2_ff;
			tgl_s1_ff <= link_tgl;
			tgl_s2_ff <= tgl_s1_ff;
			tgl_s3_ff <= tgl_s2_ff;
			scl_lv_ff <= nxt_scl_lv;
			sda_lv_ff <= nxt_sda_lv;
			tgl_lv_ff <= nxt_tgl_lv;
		end
	end

	// Byte-level engine. Bits arrive as events from the link domain; the
	// line is driven or released on accepted falling clock edges so that it
	// only ever changes while the bus clock is low.
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_sh    = sh_ff;
		nxt_tx    = tx_ff;
		nxt_idx   = idx_ff;
		nxt_rw    = rw_ff;
		nxt_inc   = 1'b0;
		nxt_oe    = oe_ff;
		nxt_addr  = addr_ff;
		nxt_wd    = wd_ff;
		nxt_wstb  = 1'b0;
		nxt_rstb  = 1'b0;
		rx_byte   = {sh_ff, link_bit};
		// Addressed means neither idle nor still listening for an address.
		nxt_busy  = (state_ff != ira_pkg::IRA_IDLE) && (state_ff != ira_pkg::IRA_ADDR);
		// The bump waits one cycle so the write strobe sees the old address.
		if (inc_ff) begin
			nxt_addr = addr_ff + `IRA_ADDR_W'(1);
		end
		if (start_ev) begin
			// A start, repeated or not, drops any partial byte and listens.
			nxt_state = ira_pkg::IRA_ADDR;
			nxt_cnt   = 3'h0;
			nxt_idx   = `IRA_IDX_HI;
			nxt_oe    = 1'b0;
		end else if (stop_ev) begin
			nxt_state = ira_pkg::IRA_IDLE;
			nxt_oe    = 1'b0;
		end else begin
			unique case (state_ff)
				ira_pkg::IRA_IDLE: begin
					// Not addressed; wait for the next start.
					nxt_oe = 1'b0;
				end
				ira_pkg::IRA_ADDR: begin
					if (bit_ev) begin
						nxt_sh  = rx_byte[6:0];
						nxt_cnt = cnt_ff + 3'h1;
						if (cnt_ff == `IRA_LAST_BIT) begin
							// Another target's address leaves the line alone.
							if (rx_byte[7:1] == DEV_ADDR) begin
								nxt_rw    = (rx_byte[0] == `IRA_DIR_READ);
								nxt_state = ira_pkg::IRA_ACK_DRV;
							end else begin
								nxt_state = ira_pkg::IRA_IDLE;
							end
						end
					end
				end
				ira_pkg::IRA_RX: begin
					if (bit_ev) begin
						nxt_sh  = rx_byte[6:0];
						nxt_cnt = cnt_ff + 3'h1;
						if (cnt_ff == `IRA_LAST_BIT) begin
							nxt_state = ira_pkg::IRA_ACK_DRV;
							unique case (idx_ff)
								`IRA_IDX_HI: begin
									nxt_addr[15:8] = rx_byte;
									nxt_idx        = `IRA_IDX_LO;
								end
								`IRA_IDX_LO: begin
									nxt_addr[7:0] = rx_byte;
									nxt_idx       = `IRA_IDX_DATA;
								end
								default: begin
									nxt_wd   = rx_byte;
									nxt_wstb = 1'b1;
									nxt_inc  = 1'b1;
								end
							endcase
						end
					end
				end
				ira_pkg::IRA_ACK_DRV: begin
					// Every byte taken is acknowledged in the ninth slot.
					if (fall_ev) begin
						nxt_oe    = (`IRA_ACK_LVL == 1'b0);
						nxt_state = ira_pkg::IRA_ACK_HOLD;
					end
				end
				ira_pkg::IRA_ACK_HOLD: begin
					if (fall_ev) begin
						nxt_cnt = 3'h0;
						if (rw_ff) begin
							// Read: first bit goes out as the slot ends.
							nxt_tx    = rd_data;
							nxt_rstb  = 1'b1;
							nxt_oe    = ~rd_data[7];
							nxt_state = ira_pkg::IRA_TX;
						end else begin
							nxt_oe    = 1'b0;
							nxt_state = ira_pkg::IRA_RX;
						end
					end
				end
				ira_pkg::IRA_TX: begin
					if (bit_ev) begin
						nxt_cnt = cnt_ff + 3'h1;
						if (cnt_ff == `IRA_LAST_BIT) begin
							nxt_state = ira_pkg::IRA_TX_REL;
						end
					end else if (fall_ev) begin
						nxt_tx = {tx_ff[6:0], 1'b0};
						nxt_oe = ~tx_ff[6];
					end
				end
				ira_pkg::IRA_TX_REL: begin
					// Free the line for the master's answer.
					if (fall_ev) begin
						nxt_oe    = 1'b0;
						nxt_inc   = 1'b1;
						nxt_state = ira_pkg::IRA_TX_ACK;
					end
				end
				ira_pkg::IRA_TX_ACK: begin
					if (bit_ev) begin
						if (link_bit == `IRA_ACK_LVL) begin
							nxt_state = ira_pkg::IRA_ACK_HOLD;
						end else begin
							nxt_state = ira_pkg::IRA_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Engine registers; the pointer survives between frames so an address
	// set by one frame serves a later read frame.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ira_pkg::IRA_IDLE;
			cnt_ff   <= 3'h0;
			sh_ff    <= 7'h00;
			tx_ff    <= `IRA_BYTE_RST;
			idx_ff   <= `IRA_IDX_HI;
			rw_ff    <= 1'b0;
			inc_ff   <= 1'b0;
			oe_ff    <= 1'b0;
			addr_ff  <= `IRA_ADDR_RST;
			wd_ff    <= `IRA_BYTE_RST;
			wstb_ff  <= 1'b0;
			rstb_ff  <= 1'b0;
			busy_ff  <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			sh_ff    <= nxt_sh;
			tx_ff    <= nxt_tx;
			idx_ff   <= nxt_idx;
			rw_ff    <= nxt_rw;
			inc_ff   <= nxt_inc;
			oe_ff    <= nxt_oe;
			addr_ff  <= nxt_addr;
			wd_ff    <= nxt_wd;
			wstb_ff  <= nxt_wstb;
			rstb_ff  <= nxt_rstb;
			busy_ff  <= nxt_busy;
		end
	end

	// Open drain: the drive value is a constant low, the enable does the work.
	assign sda_o    = 1'b0;
	assign sda_oe   = oe_ff;
	assign reg_addr = addr_ff;
	assign wr_data  = wd_ff;
	assign wr_stb   = wstb_ff;
	assign rd_stb   = rstb_ff;
	assign busy     = busy_ff;

endmodule

// ==== test/ira_i2c_target_properties.sv ====
// Port checker for the I2C register-access target.
// Assumes it is bound onto every ira_i2c_target instance.
`timescale 1ns/10ps
`include "ira_params.svh"
module ira_i2c_target_properties #(
	parameter logic [6:0] DEV_ADDR = `IRA_DEV_ADDR  // Target address, passed on by the bind.
) (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire logic                   ce,
	input wire logic                   scl,
	input wire logic                   sda_i,
	input wire logic                   sda_o,
	input wire logic                   sda_oe,
	input wire logic [`IRA_ADDR_W-1:0] reg_addr,
	input wire logic [`IRA_BYTE_W-1:0] wr_data,
	input wire logic                   wr_stb,
	input wire logic                   rd_stb,
	input wire logic [`IRA_BYTE_W-1:0] rd_data,
	input wire logic                   busy
);
	// All checks live in the system clock domain.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// The line is pulled only while addressed, and only ever towards low.
	AST_DRIVE_LOW: assert property (sda_oe |-> (sda_o == 1'b0) && busy)
		else $error("sda pulled while not addressed");
	AST_WR_ONE: assert property (wr_stb |=> !wr_stb) else $error("write strobe too long");
	AST_RD_ONE: assert property (rd_stb |=> !rd_stb) else $error("read strobe too long");
	AST_WR_ADV: assert property (wr_stb |=> reg_addr == $past(reg_addr) + 16'h0001)
		else $error("pointer did not advance after write");
	AST_WR_HOLD: assert property (wr_stb |=> $stable(wr_data)) else $error("write data moved");
	// The line may only change while the bus clock is low, or a start or stop is faked.
	AST_OE_LOW: assert property ($changed(sda_oe) |-> !scl) else $error("sda moved in high");
	AST_ONE_DIR: assert property (!(wr_stb && rd_stb)) else $error("read and write at once");
	AST_STB_BUSY: assert property ((wr_stb || rd_stb) |-> busy) else $error("strobe when idle");
	AST_STOP_IDLE: assert property (scl && $past(scl) && $rose(sda_i) |-> ##[1:8] !busy)
		else $error("stop did not end the frame");
	COV_WR: cover property (wr_stb);
	COV_RD: cover property (rd_stb);
	COV_END: cover property ($fell(busy));
endmodule
bind ira_i2c_target ira_i2c_target_properties #(.DEV_ADDR(DEV_ADDR)) u_props (.clk(clk),
	.rst_n(rst_n), .ce(ce), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
	.reg_addr(reg_addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rd_data(rd_data), .busy(busy));

// ==== test/ira_master_model.sv ====
// Behavioural I2C bus master that drives the bus clock and pulls the data line.
// Assumes the bench resolves the open-drain line with a pull-up and feeds it back.
`timescale 1ns/10ps
module ira_master_model (
	input  wire logic clk,     // System clock that paces the bus phases.
	input  wire logic sda,     // Resolved data line level.
	output logic      scl,     // Bus clock, held high between frames.
	output logic      sda_oe   // High while this master pulls the line low.
);
	// Quarter bit in system clocks; the target's synchronisers need long phases.
	localparam int Q = 5;
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic hold();
		repeat (Q) @(posedge clk);
	endtask
	// One bit: change data while the clock is low, sample mid-high.
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		hold();
		sda_oe <= ~b;
		hold();
		scl <= 1'b1;
		hold();
		r = sda;
		hold();
	endtask
	// Start or repeated start: release, clock high, then pull low.
	task automatic start();
		scl <= 1'b0;
		hold();
		sda_oe <= 1'b0;
		hold();
		scl <= 1'b1;
		hold();
		sda_oe <= 1'b1;
		hold();
	endtask
	task automatic stop();
		scl <= 1'b0;
		hold();
		sda_oe <= 1'b1;
		hold();
		scl <= 1'b1;
		hold();
		sda_oe <= 1'b0;
		hold();
	endtask
	// Sends n bits MSB first; a whole byte also clocks the acknowledge slot.
	task automatic send(input logic [7:0] d, input int n, output logic ack);
		logic r;
		ack = 1'b1;
		for (int i = 7; i > 7 - n; i--) bit_io(d[i], r);
		if (n == 8) bit_io(1'b1, ack);
	endtask
	// Receives a byte, then leaves the last one unacknowledged.
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			d = {d[6:0], r};
		end
		bit_io(last, r);
	endtask
endmodule

// ==== test/ira_i2c_target_bench.sv ====
// Self-checking bench for the I2C register-access target.
// Assumes ira_master_model on the bus and a register array here behind the strobes.
`timescale 1ns/10ps
`include "ira_params.svh"
module ira_i2c_target_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        m_scl, m_oe, sda, sda_o, sda_oe, wr_stb, rd_stb, busy;
	logic [15:0] reg_addr;
	logic [7:0]  wr_data, d;
	logic [7:0]  rd_data = 8'h00;
	logic [7:0]  mem [0:65535];  // Register space served to the target.
	int          n_fail, cmp_count, n_wr, n_rd;
	always #25 clk = ~clk;
	// Open drain with a pull-up: low when either party pulls.
	assign sda = !(m_oe || (sda_oe && !sda_o));
	ira_master_model m (.clk(clk), .sda(sda), .scl(m_scl), .sda_oe(m_oe));
	ira_i2c_target dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .scl(m_scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .reg_addr(reg_addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .busy(busy));
	// The register file answers within one clock and records every store.
	always @(posedge clk) begin
		rd_data <= mem[reg_addr];
		if (wr_stb === 1'b1) begin
			mem[reg_addr] <= wr_data;
			n_wr++;
		end
		// Every byte fetched for the line is counted, so lost or extra fetches show.
		if (rd_stb === 1'b1) n_rd++;
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic snd(input logic [7:0] b, input logic exp);
		logic a;
		m.send(b, 8, a);
		check("ack", a, exp);
	endtask
	// Settles before judging; NACK and stop both end the frame.
	task automatic idle_chk();
		for (int i = 0; i < 10 && busy !== 1'b0; i++) @(posedge clk);
		check("busy", busy, 1'b0);
	endtask
	task automatic t_write();
		m.start();
		snd(8'h54, 1'b0);
		check("busy_on", busy, 1'b1);
		snd(8'h12, 1'b0);
		snd(8'h34, 1'b0);
		snd(8'hA5, 1'b0);
		snd(8'h5A, 1'b0);
		m.stop();
		check("mem0", mem[16'h1234], 8'hA5);
		check("mem1", mem[16'h1235], 8'h5A);
		check("ptr", reg_addr, 16'h1236);
	endtask
	task automatic t_combined();
		int r0;
		r0 = n_rd;
		m.start();
		snd(8'h54, 1'b0);
		snd(8'h12, 1'b0);
		snd(8'h34, 1'b0);
		m.start();
		snd(8'h55, 1'b0);
		m.recv(1'b0, d);
		check("rd0", d, 8'hA5);
		m.recv(1'b1, d);
		check("rd1", d, 8'h5A);
		check("rd_cnt", 16'(n_rd - r0), 16'h0002);
		idle_chk();
		m.stop();
	endtask
	task automatic t_setup_recv();
		m.start();
		snd(8'h54, 1'b0);
		snd(8'h12, 1'b0);
		snd(8'h35, 1'b0);
		m.stop();
		m.start();
		snd(8'h55, 1'b0);
		m.recv(1'b1, d);
		check("rd", d, 8'h5A);
		m.stop();
		idle_chk();
	endtask
	// Another address is left unacknowledged and stores nothing.
	task automatic t_refuse();
		int w0;
		w0 = n_wr;
		m.start();
		snd(8'h56, 1'b1);
		check("busy_off", busy, 1'b0);
		m.stop();
		check("wr_cnt", 16'(n_wr), 16'(w0));
	endtask
	// A stop in mid-byte drops it; the next frame still lines up.
	task automatic t_abort();
		logic a;
		int   w0;
		w0 = n_wr;
		m.start();
		snd(8'h54, 1'b0);
		snd(8'h12, 1'b0);
		snd(8'h34, 1'b0);
		m.send(8'hF0, 4, a);
		m.stop();
		idle_chk();
		check("wr_cnt", 16'(n_wr), 16'(w0));
		m.start();
		snd(8'h54, 1'b0);
		snd(8'h12, 1'b0);
		snd(8'h34, 1'b0);
		snd(8'h3C, 1'b0);
		m.stop();
		check("mem0", mem[16'h1234], 8'h3C);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_write();
		t_combined();
		t_setup_recv();
		t_refuse();
		t_abort();
		close_out();
	end
	// About 25 bus bytes of 180 clocks each should finish well inside this span.
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule
